// ### design/prdd_pin_sync.sv
// two flip-flop synchroniser for the port input pins
`timescale 1ns/1ps
module prdd_pin_sync #(
  parameter int unsigned WIDTH = 8
) (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  // raw pin levels
  input wire logic [WIDTH-1:0] i_pin,
  // levels safe to read in the clock domain
  output logic [WIDTH-1:0] o_pin_sync
);

  //////////////////////////////////////////////////////////////////////////////
  // one pair of flops per pin; the first flop feeds only the second
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta_reg; // first stage, may go metastable
      logic meta_next;
      logic sync_reg; // second stage, safe for logic
      logic sync_next;
      // next values
      always_comb begin
        meta_next = i_pin[g];
        sync_next = meta_reg;
      end
      // register only
      always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= meta_next;
          sync_reg <= sync_next;
        end
      end
      assign o_pin_sync[g] = sync_reg;
    end
  endgenerate

endmodule

// ### design/prdd_pkg.sv
// shared constants of the eight-bit port with data latch and direction control
package prdd_pkg;
  // port width and bus widths
  localparam int unsigned PORT_W = 8;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned WORD_W = 16;
  // register addresses on the peripheral bus
  localparam logic [ADDR_W-1:0] ADDR_DATA_LATCH = 16'hFFD6;
  localparam logic [ADDR_W-1:0] ADDR_DIR_CTRL = 16'hFFE6;
  // reset values: every pin an input, latch cleared
  localparam logic [PORT_W-1:0] RST_DATA_LATCH = 8'h00;
  localparam logic [PORT_W-1:0] RST_DIR_CTRL = 8'h00;
  // read answers
  localparam logic [PORT_W-1:0] DIR_READ_VALUE = 8'hFF;
  localparam logic [PORT_W-1:0] UNMAPPED_READ = 8'h00;
  localparam logic [PORT_W-1:0] WORD_LOW_FILL = 8'h00;
  // bus access phases
  typedef enum logic [1:0] {PRDD_IDLE, PRDD_READ, PRDD_WRITE} prdd_phase_t;
endpackage

// ### design/prdd_port.sv
// eight-bit port: data latch, write-only direction control, pin readback
`timescale 1ns/1ps
module prdd_port #(
  parameter int unsigned PORT_W = prdd_pkg::PORT_W
) (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  // peripheral bus request
  input wire logic [prdd_pkg::ADDR_W-1:0] I_ADDR,
  input wire logic I_RD,
  input wire logic I_WR,
  input wire logic I_WORD,
  input wire logic [prdd_pkg::WORD_W-1:0] I_WDATA,
  // peripheral bus answer
  output logic [prdd_pkg::WORD_W-1:0] O_RDATA,
  output logic O_RVALID,
  // pins
  input wire logic [PORT_W-1:0] I_PIN,
  output logic [PORT_W-1:0] O_PIN_OUT,
  output logic [PORT_W-1:0] O_PIN_OE
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [PORT_W-1:0] pin_sync; // pin levels after two flops
  logic [PORT_W-1:0] latch_reg; // data latch
  logic [PORT_W-1:0] latch_next;
  logic [PORT_W-1:0] dir_reg; // direction, one means output
  logic [PORT_W-1:0] dir_next;
  logic [prdd_pkg::WORD_W-1:0] rdata_reg; // registered read answer
  logic [prdd_pkg::WORD_W-1:0] rdata_next;
  logic rvalid_reg; // answer strobe
  logic rvalid_next;
  logic [PORT_W-1:0] wbyte; // byte lane that reaches the register
  logic [PORT_W-1:0] rbyte; // byte that a read returns
  logic hit_data; // address decode
  logic hit_dir;
  prdd_pkg::prdd_phase_t phase; // kind of access this cycle

  //////////////////////////////////////////////////////////////////////////////
  // pin synchroniser
  prdd_pin_sync #(
    .WIDTH(PORT_W)
  ) u_sync (
    .I_CLK(I_CLK),
    .I_ARST_N(I_ARST_N),
    .i_pin(I_PIN),
    .o_pin_sync(pin_sync)
  );

  //////////////////////////////////////////////////////////////////////////////
  // decode and lane selection
  always_comb begin
    hit_data = (I_ADDR == prdd_pkg::ADDR_DATA_LATCH);
    hit_dir = (I_ADDR == prdd_pkg::ADDR_DIR_CTRL);
    // write takes precedence if a master drives both strobes
    if (I_WR) begin
      phase = prdd_pkg::PRDD_WRITE;
    end else if (I_RD) begin
      phase = prdd_pkg::PRDD_READ;
    end else begin
      phase = prdd_pkg::PRDD_IDLE;
    end
    // a word write only lands its upper byte; lower byte is lost
    if (I_WORD) begin
      wbyte = I_WDATA[prdd_pkg::WORD_W-1:PORT_W];
    end else begin
      wbyte = I_WDATA[PORT_W-1:0];
    end
    // pins come through two flops, so a read lags a pin change by two edges;
    // the latency buys read data that is never metastable
    // read byte: pins for inputs, latch for outputs
    if (hit_data) begin
      rbyte = (pin_sync & ~dir_reg) | (latch_reg & dir_reg);
    end else if (hit_dir) begin
      rbyte = prdd_pkg::DIR_READ_VALUE;
    end else begin
      rbyte = prdd_pkg::UNMAPPED_READ;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register next values
  always_comb begin
    latch_next = latch_reg;
    dir_next = dir_reg;
    rdata_next = rdata_reg;
    rvalid_next = 1'b0;
    case (phase)
      prdd_pkg::PRDD_WRITE: begin
        // all eight bits stored, even for input pins
        if (hit_data) begin
          latch_next = wbyte;
        end
        // no readback exists, so software must write whole bytes
        if (hit_dir) begin
          dir_next = wbyte;
        end
      end
      prdd_pkg::PRDD_READ: begin
        // word read: upper byte is the register, lower byte is filler
        if (I_WORD) begin
          rdata_next = {rbyte, prdd_pkg::WORD_LOW_FILL};
        end else begin
          rdata_next = {{(prdd_pkg::WORD_W-PORT_W){1'b0}}, rbyte};
        end
        rvalid_next = 1'b1;
      end
      prdd_pkg::PRDD_IDLE: begin
        rvalid_next = 1'b0;
      end
      default: begin
        rvalid_next = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      latch_reg <= prdd_pkg::RST_DATA_LATCH;
      dir_reg <= prdd_pkg::RST_DIR_CTRL;
      rdata_reg <= '0;
      rvalid_reg <= 1'b0;
    end else begin
      latch_reg <= latch_next;
      dir_reg <= dir_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs straight from flops; enable high drives the pin
  // level and enable come from separate flops, so a direction write never glitches the level
  assign O_PIN_OUT = latch_reg;
  assign O_PIN_OE = dir_reg;
  assign O_RDATA = rdata_reg;
  assign O_RVALID = rvalid_reg;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);

  // byte read of the data latch
  sequence s_data_read;
    I_RD && !I_WR && !I_WORD && hit_data;
  endsequence
  // byte write of the data latch with all pins outputs
  sequence s_data_write_out;
    I_WR && !I_WORD && hit_data && (dir_reg == prdd_pkg::DIR_READ_VALUE);
  endsequence
  // latch write, one idle cycle, then a byte read of the same latch
  sequence s_write_gap_read;
    s_data_write_out ##1 !I_WR ##1 s_data_read;
  endsequence

  input_bits_a: assert property (s_data_read |=>
    ((O_RDATA[PORT_W-1:0] & ~$past(dir_reg)) == ($past(pin_sync) & ~$past(dir_reg))))
    else $error("input pin bits did not read pin level");
  output_bits_a: assert property (s_data_read |=>
    ((O_RDATA[PORT_W-1:0] & $past(dir_reg)) == ($past(latch_reg) & $past(dir_reg))))
    else $error("output pin bits did not read latch");
  dir_reads_ones_a: assert property (I_RD && !I_WR && hit_dir && !I_WORD |=>
    O_RDATA == {{(prdd_pkg::WORD_W-PORT_W){1'b0}}, prdd_pkg::DIR_READ_VALUE})
    else $error("direction read not all ones");
  latch_store_a: assert property (I_WR && !I_WORD && hit_data |=>
    latch_reg == $past(I_WDATA[PORT_W-1:0]))
    else $error("data write not stored in full");
  pin_drive_a: assert property (I_WR && !I_WORD && hit_data |=>
    O_PIN_OUT == $past(I_WDATA[PORT_W-1:0]))
    else $error("pin output does not follow latch");
  dir_store_a: assert property (I_WR && !I_WORD && hit_dir |=>
    O_PIN_OE == $past(I_WDATA[PORT_W-1:0]))
    else $error("direction write not applied");
  // direction only moves on a direction write
  dir_hold_a: assert property (!(I_WR && hit_dir) |=>
    $stable(O_PIN_OE))
    else $error("direction changed without a write");
  // latch only moves on a latch write, so pin levels never drift
  latch_hold_a: assert property (!(I_WR && hit_data) |=>
    $stable(O_PIN_OUT))
    else $error("latch changed without a write");
  rmw_back_a: assert property (s_write_gap_read |=>
    O_RDATA[PORT_W-1:0] == $past(I_WDATA[PORT_W-1:0], 3))
    else $error("written byte did not read back");
  word_upper_a: assert property (I_WR && I_WORD && hit_data |=>
    latch_reg == $past(I_WDATA[prdd_pkg::WORD_W-1:PORT_W]))
    else $error("word write did not store upper byte");
  word_read_a: assert property (I_RD && !I_WR && I_WORD |=>
    O_RDATA[PORT_W-1:0] == prdd_pkg::WORD_LOW_FILL)
    else $error("word read lower byte not filler");
  read_strobe_a: assert property (I_RD && !I_WR |=>
    O_RVALID ##1 (!O_RVALID || $past(I_RD)))
    else $error("read answer strobe wrong");
  // a write wins over a read strobe and gives no answer
  write_quiet_a: assert property (I_WR |=> !O_RVALID)
    else $error("write produced a read answer");
  // unmapped byte reads answer zero
  unmapped_read_a: assert property (I_RD && !I_WR && !I_WORD && !hit_data && !hit_dir |=>
    O_RDATA == {{(prdd_pkg::WORD_W-PORT_W){1'b0}}, prdd_pkg::UNMAPPED_READ})
    else $error("unmapped read not zero");

endmodule

// ### tb/prdd_cpu_model.sv
// behavioural cpu core issuing byte and word cycles on the peripheral bus
`timescale 1ns/1ps
module prdd_cpu_model (
  // clock and read answer
  input wire logic i_clk,
  input wire logic [15:0] i_rdata,
  input wire logic i_rvalid,
  // bus request
  output logic [15:0] o_addr,
  output logic o_rd,
  output logic o_wr,
  output logic o_word,
  output logic [15:0] o_wdata
);
  // idle bus, nothing requested before reset ends
  initial begin
    o_addr = 16'h0000;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_word = 1'b0;
    o_wdata = 16'h0000;
  end
  // one write cycle; data is scrambled once taken so stale data never helps
  task automatic wr_cyc(input logic [15:0] a, input logic [15:0] d, input logic w);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_word = w;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_wdata = ~d;
  endtask
  // one read cycle; answer sampled in the cycle after the strobe
  task automatic rd_cyc(input logic [15:0] a, input logic w, output logic [15:0] d,
                        output logic v);
    @(negedge i_clk);
    o_addr = a;
    o_word = w;
    o_rd = 1'b1;
    @(negedge i_clk);
    o_rd = 1'b0;
    d = i_rdata;
    v = i_rvalid;
  endtask
  // bit set or clear done the way the core does it: whole-byte read, modify, write
  task automatic bit_op(input logic [15:0] a, input int n, input logic s);
    logic [15:0] d;
    logic v;
    rd_cyc(a, 1'b0, d, v);
    d[n] = s;
    wr_cyc(a, d, 1'b0);
  endtask
endmodule

// ### tb/prdd_port_bench.sv
// self-checking bench of the eight-bit port
`timescale 1ns/1ps
module prdd_port_bench;
  logic I_CLK, I_ARST_N, I_RD, I_WR, I_WORD, O_RVALID;
  logic [15:0] I_ADDR, I_WDATA, O_RDATA, d;
  logic [7:0] I_PIN, O_PIN_OUT, O_PIN_OE;
  logic v;
  logic [7:0] shadow;
  int error_cnt = 0;
  int checks = 0;
  // rows: direction, latch, pins, expected data read
  logic [31:0] rows [4] = '{32'h00804040, 32'hFF5AA55A, 32'h3F804040, 32'hC30FF033};
  localparam logic [15:0] AD = prdd_pkg::ADDR_DATA_LATCH;
  localparam logic [15:0] AC = prdd_pkg::ADDR_DIR_CTRL;
  prdd_port u_dut (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_ADDR(I_ADDR), .I_RD(I_RD),
    .I_WR(I_WR), .I_WORD(I_WORD), .I_WDATA(I_WDATA), .O_RDATA(O_RDATA),
    .O_RVALID(O_RVALID), .I_PIN(I_PIN), .O_PIN_OUT(O_PIN_OUT), .O_PIN_OE(O_PIN_OE));
  prdd_cpu_model u_cpu (.i_clk(I_CLK), .i_rdata(O_RDATA), .i_rvalid(O_RVALID),
    .o_addr(I_ADDR), .o_rd(I_RD), .o_wr(I_WR), .o_word(I_WORD), .o_wdata(I_WDATA));
  // 125 MHz clock
  initial begin
    I_CLK = 1'b0;
    forever #4 I_CLK = ~I_CLK;
  end
  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic final_report();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // watchdog so a hang cannot run forever
  initial begin
    #100000;
    error_cnt++;
    final_report();
  end
  // main sequence
  initial begin
    I_ARST_N = 1'b0;
    I_PIN = 8'h00;
    repeat (10) @(negedge I_CLK);
    I_ARST_N = 1'b1;
    chk({8'h00, O_PIN_OE}, 16'h0000);
    chk({8'h00, O_PIN_OUT}, 16'h0000);
    // table of direction cases: all inputs, all outputs, mixed
    foreach (rows[i]) begin
      u_cpu.wr_cyc(AC, {8'h00, rows[i][31:24]}, 1'b0);
      u_cpu.wr_cyc(AD, {8'h00, rows[i][23:16]}, 1'b0);
      I_PIN = rows[i][15:8];
      repeat (3) @(negedge I_CLK);
      u_cpu.rd_cyc(AD, 1'b0, d, v);
      chk(d, {8'h00, rows[i][7:0]});
      chk({15'h0000, v}, 16'h0001);
      chk({8'h00, O_PIN_OE}, {8'h00, rows[i][31:24]});
      chk({8'h00, O_PIN_OUT}, {8'h00, rows[i][23:16]});
    end
    // all outputs: a latch write reads straight back after one idle cycle
    u_cpu.wr_cyc(AC, 16'h00FF, 1'b0);
    u_cpu.wr_cyc(AD, 16'h0096, 1'b0);
    u_cpu.rd_cyc(AD, 1'b0, d, v);
    chk(d, 16'h0096);
    // direction reads all ones whatever is stored
    u_cpu.rd_cyc(AC, 1'b0, d, v);
    chk(d, 16'h00FF);
    // bit set on the data latch picks up the input pin levels
    u_cpu.wr_cyc(AC, 16'h003F, 1'b0);
    u_cpu.wr_cyc(AD, 16'h0080, 1'b0);
    I_PIN = 8'h40;
    repeat (3) @(negedge I_CLK);
    u_cpu.bit_op(AD, 0, 1'b1);
    chk({8'h00, O_PIN_OUT}, 16'h0041);
    // bit clear on the direction byte turns inputs into outputs
    u_cpu.bit_op(AC, 0, 1'b0);
    chk({8'h00, O_PIN_OE}, 16'h00FE);
    // word access: upper byte only
    u_cpu.wr_cyc(AD, 16'h5A33, 1'b1);
    chk({8'h00, O_PIN_OUT}, 16'h005A);
    u_cpu.rd_cyc(AD, 1'b1, d, v);
    chk(d, 16'h5A00);
    // shadow copy of the latch: modify in memory, write the whole byte
    shadow = 8'h80;
    u_cpu.wr_cyc(AC, 16'h003F, 1'b0);
    u_cpu.wr_cyc(AD, {8'h00, shadow}, 1'b0);
    shadow[0] = 1'b1;
    u_cpu.wr_cyc(AD, {8'h00, shadow}, 1'b0);
    chk({8'h00, O_PIN_OUT}, 16'h0081);
    // shadow copy of the direction byte keeps the input pins as inputs
    shadow = 8'h3F;
    shadow[0] = 1'b0;
    u_cpu.wr_cyc(AC, {8'h00, shadow}, 1'b0);
    chk({8'h00, O_PIN_OE}, 16'h003E);
    // unmapped place reads zero
    u_cpu.rd_cyc(16'hFFD7, 1'b0, d, v);
    chk(d, 16'h0000);
    // reset in mid-run returns every pin to input
    I_ARST_N = 1'b0;
    @(negedge I_CLK);
    chk({8'h00, O_PIN_OE}, 16'h0000);
    chk({8'h00, O_PIN_OUT}, 16'h0000);
    chk({15'h0000, O_RVALID}, 16'h0000);
    chk(O_RDATA, 16'h0000);
    I_ARST_N = 1'b1;
    // first cycles after release: latch takes all bits, direction reads ones
    u_cpu.wr_cyc(AD, 16'h000F, 1'b0);
    chk({8'h00, O_PIN_OUT}, 16'h000F);
    u_cpu.rd_cyc(AC, 1'b0, d, v);
    chk(d, 16'h00FF);
    final_report();
  end
endmodule
